// ===== logic/fcra_consts.vh
// Command codes, identification addresses and timing counts for the flash command host
`ifndef FCRA_CONSTS_VH
`define FCRA_CONSTS_VH
`define FCRA_CMD_READ       8'h00
`define FCRA_CMD_SETUP_PGM  8'h40
`define FCRA_CMD_ID_A       8'h80
`define FCRA_CMD_ID_B       8'h90
`define FCRA_CMD_RESET      8'hFF
`define FCRA_ADDR_MFR       16'h0000
`define FCRA_ADDR_DEV       16'h0001
`define FCRA_CLK_MHZ        40
`define FCRA_WR_TO_RD_US    6
`define FCRA_WR_TO_RD_CYC   (`FCRA_WR_TO_RD_US * `FCRA_CLK_MHZ)
`define FCRA_SETUP_CYC      2
`define FCRA_PULSE_CYC      3
`define FCRA_HOLD_CYC       2
`define FCRA_READ_CYC       6
`define FCRA_OP_NONE        3'h0
`define FCRA_OP_RESET       3'h1
`define FCRA_OP_READ_ID     3'h2
`define FCRA_OP_READ_MODE   3'h3
`define FCRA_OP_ABORT_PGM   3'h4
`endif

// ===== logic/fcra_bus_cycle.v
// One write or read cycle on the flash parallel bus, strobe timing in core clocks
`timescale 1ns/1ps
`include "fcra_consts.vh"
module fcra_bus_cycle (
	input  wire        core_clk,   // System clock
	input  wire        sys_rst,    // Synchronous reset
	input  wire        clk_en,     // Clock enable
	input  wire        start,      // Begin a cycle
	input  wire        is_write,   // 1 write, 0 read
	input  wire [15:0] addr,       // Cycle address
	input  wire [7:0]  wdata,      // Write data
	input  wire [7:0]  pin_dq_in,  // Synchronised data pins
	output reg         busy,       // Cycle in progress
	output reg         done,       // Cycle finished pulse
	output reg  [7:0]  rdata,      // Captured read data
	output reg  [15:0] pin_addr,   // Address pins
	output reg  [7:0]  pin_dq_out, // Data pins out
	output reg         pin_dq_oe,  // Data pins drive enable
	output reg         ce_n,       // Chip enable
	output reg         we_n,       // Write strobe
	output reg         oe_n        // Output enable
);
	localparam S_IDLE  = 4'b0001;
	localparam S_SETUP = 4'b0010;
	localparam S_PULSE = 4'b0100;
	localparam S_HOLD  = 4'b1000;
	reg [3:0] state_reg;
	reg [3:0] cnt_reg;
	reg       wr_reg;
	always @(posedge core_clk) begin
		if (sys_rst) begin
			state_reg <= S_IDLE;
			cnt_reg <= 4'h0;
			wr_reg <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			rdata <= 8'h00;
			pin_addr <= 16'h0000;
			pin_dq_out <= 8'h00;
			pin_dq_oe <= 1'b0;
			ce_n <= 1'b1;
			we_n <= 1'b1;
			oe_n <= 1'b1;
		end else if (clk_en) begin
			done <= 1'b0;
			case (state_reg)
				S_IDLE: begin
					if (start) begin
						// Address set up ahead of the falling strobe, data ahead of rising
						pin_addr <= addr;
						pin_dq_out <= wdata;
						pin_dq_oe <= is_write;
						wr_reg <= is_write;
						ce_n <= 1'b0;
						busy <= 1'b1;
						cnt_reg <= 4'h0;
						state_reg <= S_SETUP;
					end
				end
				S_SETUP: begin
					if (cnt_reg == `FCRA_SETUP_CYC - 1) begin
						cnt_reg <= 4'h0;
						we_n <= ~wr_reg;
						oe_n <= wr_reg;
						state_reg <= S_PULSE;
					end else begin
						cnt_reg <= cnt_reg + 4'h1;
					end
				end
				S_PULSE: begin
					if (cnt_reg == (wr_reg ? `FCRA_PULSE_CYC - 1 : `FCRA_READ_CYC - 1)) begin
						cnt_reg <= 4'h0;
						we_n <= 1'b1;
						oe_n <= 1'b1;
						if (!wr_reg)
							rdata <= pin_dq_in;
						state_reg <= S_HOLD;
					end else begin
						cnt_reg <= cnt_reg + 4'h1;
					end
				end
				S_HOLD: begin
					// Address and data held past the rising strobe
					if (cnt_reg == `FCRA_HOLD_CYC - 1) begin
						pin_dq_oe <= 1'b0;
						ce_n <= 1'b1;
						busy <= 1'b0;
						done <= 1'b1;
						state_reg <= S_IDLE;
					end else begin
						cnt_reg <= cnt_reg + 4'h1;
					end
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end
endmodule

// ===== logic/fcra_host.v
// Host sequencer that issues reset, abort and identification sequences to a bytewide flash
`timescale 1ns/1ps
`include "fcra_consts.vh"
// Contract
// - After a set-up command the host writes FFH twice back to back to cancel the operation.
// - After cancelling, a valid command must be written before relying on any other state; the abort sequence ends at the second FFH.
// - The host issues the reset sequence first after its own reset, ahead of any user request.
// - Identification mode is left only by writing a new command, which the host does with 00H.
// - After a command ending erase or program the host waits at least 6 us before a read.
module fcra_host (
	input  wire        core_clk,           // 40 MHz clock
	input  wire        sys_rst,            // Synchronous reset, active high
	input  wire        clk_en,             // Clock enable, freezes state when low
	input  wire        req_valid,          // User request strobe
	input  wire [2:0]  req_op,             // Requested operation
	input  wire [7:0]  pin_dq_in,          // Flash data pins in
	input  wire        program_supply_low_level, // Supply sensed at read-only level, asynchronous
	output reg         req_ready,          // Ready for a request
	output reg         resp_valid,         // Operation done pulse
	output reg  [7:0]  resp_mfr,           // Captured maker code
	output reg  [7:0]  resp_dev,           // Captured device code
	output reg         supply_low,         // Synchronised supply-low status
	output wire [15:0] pin_addr,           // Flash address pins
	output wire [7:0]  pin_dq_out,         // Flash data pins out
	output wire        pin_dq_oe,          // Flash data drive enable
	output wire        flash_ce_n,         // Flash chip enable
	output wire        flash_we_n,         // Flash write strobe
	output wire        flash_oe_n          // Flash output enable
);
	localparam S_IDLE  = 6'b000001;
	localparam S_ISSUE = 6'b000010;
	localparam S_WAIT  = 6'b000100;
	localparam S_GAP   = 6'b001000;
	localparam S_DONE  = 6'b010000;
	localparam S_BOOT  = 6'b100000;
	// Six microseconds of core clocks, cut to the gap counter width on purpose
	localparam integer RECOV_INT = `FCRA_WR_TO_RD_CYC;
	localparam [8:0]   RECOV_CYC = RECOV_INT[8:0];
	reg [5:0]  state_reg;
	reg [2:0]  op_reg;
	reg [2:0]  step_reg;
	reg [8:0]  gap_reg;
	reg        boot_reg;
	reg        vpp_meta_reg;
	reg        start_reg;
	reg        wr_sel;
	reg [15:0] a_sel;
	reg [7:0]  d_sel;
	reg        last_sel;
	wire       cyc_busy;
	wire       cyc_done;
	wire [7:0] cyc_rdata;
	wire [7:0] dq_sync;
	// Per-step script of each operation
	always @* begin
		wr_sel = 1'b1;
		a_sel = 16'h0000;
		d_sel = `FCRA_CMD_RESET;
		last_sel = 1'b0;
		case (op_reg)
			`FCRA_OP_RESET: begin
				last_sel = (step_reg == 3'h1);
			end
			`FCRA_OP_ABORT_PGM: begin
				if (step_reg == 3'h0)
					d_sel = `FCRA_CMD_SETUP_PGM;
				last_sel = (step_reg == 3'h2);
			end
			`FCRA_OP_READ_ID: begin
				if (step_reg == 3'h0) begin
					d_sel = `FCRA_CMD_ID_B;
				end else if (step_reg == 3'h1) begin
					wr_sel = 1'b0;
					a_sel = `FCRA_ADDR_MFR;
				end else if (step_reg == 3'h2) begin
					wr_sel = 1'b0;
					a_sel = `FCRA_ADDR_DEV;
				end else begin
					d_sel = `FCRA_CMD_READ;
					last_sel = 1'b1;
				end
			end
			// Read-mode requests and unknown op codes both write 00H, falling back to read mode
			default: begin
				d_sel = `FCRA_CMD_READ;
				last_sel = 1'b1;
			end
		endcase
	end

	fcra_bus_cycle u_cycle (
		.core_clk   (core_clk),
		.sys_rst    (sys_rst),
		.clk_en     (clk_en),
		.start      (start_reg),
		.is_write   (wr_sel),
		.addr       (a_sel),
		.wdata      (d_sel),
		.pin_dq_in  (dq_sync),
		.busy       (cyc_busy),
		.done       (cyc_done),
		.rdata      (cyc_rdata),
		.pin_addr   (pin_addr),
		.pin_dq_out (pin_dq_out),
		.pin_dq_oe  (pin_dq_oe),
		.ce_n       (flash_ce_n),
		.we_n       (flash_we_n),
		.oe_n       (flash_oe_n)
	);

	// Pins are synchronised bit by bit; read data stands for the whole read strobe,
	// so all bits have settled long before the bus unit samples them
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_dq_sync
			reg meta_reg;
			reg sync_reg;
			always @(posedge core_clk) begin
				if (sys_rst) begin
					meta_reg <= 1'b0;
					sync_reg <= 1'b0;
				end else if (clk_en) begin
					meta_reg <= pin_dq_in[gi];
					sync_reg <= meta_reg;
				end
			end
			assign dq_sync[gi] = sync_reg;
		end
	endgenerate

	always @(posedge core_clk) begin
		if (sys_rst) begin
			vpp_meta_reg <= 1'b0;
			supply_low <= 1'b0;
		end else if (clk_en) begin
			vpp_meta_reg <= program_supply_low_level;
			supply_low <= vpp_meta_reg;
		end
	end

	always @(posedge core_clk) begin
		if (sys_rst) begin
			state_reg <= S_BOOT;
			op_reg <= `FCRA_OP_RESET;
			step_reg <= 3'h0;
			gap_reg <= 9'h000;
			boot_reg <= 1'b1;
			start_reg <= 1'b0;
			req_ready <= 1'b0;
			resp_valid <= 1'b0;
			resp_mfr <= 8'h00;
			resp_dev <= 8'h00;
		end else if (clk_en) begin
			start_reg <= 1'b0;
			resp_valid <= 1'b0;
			case (state_reg)
				S_BOOT: begin
					// Reset sequence runs before any request is taken
					op_reg <= `FCRA_OP_RESET;
					step_reg <= 3'h0;
					state_reg <= S_ISSUE;
				end
				S_IDLE: begin
					// Requests while busy are dropped, not queued
					if (req_valid && req_op != `FCRA_OP_NONE) begin
						req_ready <= 1'b0;
						op_reg <= req_op;
						step_reg <= 3'h0;
						state_reg <= S_ISSUE;
					end
				end
				S_ISSUE: begin
					if (!cyc_busy && !start_reg) begin
						start_reg <= 1'b1;
						state_reg <= S_WAIT;
					end
				end
				S_WAIT: begin
					if (cyc_done) begin
						if (!wr_sel && step_reg == 3'h1)
							resp_mfr <= cyc_rdata;
						if (!wr_sel && step_reg == 3'h2)
							resp_dev <= cyc_rdata;
						if (last_sel) begin
							state_reg <= S_DONE;
						end else begin
							step_reg <= step_reg + 3'h1;
							gap_reg <= 9'h000;
							state_reg <= S_GAP;
						end
					end
				end
				S_GAP: begin
					// A full recovery wait after every write keeps any following read clean
					if (gap_reg >= RECOV_CYC - 9'h001) begin
						state_reg <= S_ISSUE;
					end else begin
						gap_reg <= gap_reg + 9'h001;
					end
				end
				S_DONE: begin
					if (gap_reg >= RECOV_CYC - 9'h001) begin
						if (!boot_reg)
							resp_valid <= 1'b1;
						boot_reg <= 1'b0;
						req_ready <= 1'b1;
						state_reg <= S_IDLE;
					end else begin
						gap_reg <= gap_reg + 9'h001;
					end
				end
				default: state_reg <= S_IDLE;
			endcase
			if (state_reg == S_WAIT && cyc_done && last_sel)
				gap_reg <= 9'h000;
		end
	end
endmodule

// ===== sim/fcra_host_properties.sv
// Concurrent checks on the flash host pins and request handshake
`timescale 1ns/1ps
module fcra_host_properties (
	input wire logic       core_clk,   // Clock
	input wire logic       sys_rst,    // Reset
	input wire logic       req_valid,  // Request
	input wire logic [2:0] req_op,     // Operation
	input wire logic       req_ready,  // Ready
	input wire logic [7:0] pin_dq_out, // Data out
	input wire logic       pin_dq_oe,  // Data enable
	input wire logic       flash_ce_n, // Chip enable
	input wire logic       flash_we_n, // Write strobe
	input wire logic       flash_oe_n  // Output enable
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	reg [8:0] since_wr_reg;
	reg       wrote_reg;
	reg [7:0] last_cmd_reg;
	// Saturates so a read long after the last write is never flagged
	always @(posedge core_clk) begin
		if (sys_rst) begin
			since_wr_reg <= 9'h1FF;
			wrote_reg <= 1'b0;
			last_cmd_reg <= 8'h00;
		end else begin
			if (!flash_we_n)
				since_wr_reg <= 9'h000;
			else if (since_wr_reg != 9'h1FF)
				since_wr_reg <= since_wr_reg + 9'h001;
			if ($rose(flash_we_n)) begin
				wrote_reg <= 1'b1;
				last_cmd_reg <= pin_dq_out;
			end
		end
	end
	sequence s_we_low3;
		!flash_we_n [*3] ##1 flash_we_n;
	endsequence
	sequence s_take;
		req_ready && req_valid && req_op != 3'h0;
	endsequence
	a_strobe_excl: assert property (!(!flash_we_n && !flash_oe_n))
		else $error("write and output strobes low together");
	a_write_framed: assert property (!flash_we_n |-> !flash_ce_n && pin_dq_oe)
		else $error("write strobe without chip enable or data drive");
	a_read_released: assert property (!flash_oe_n |-> !pin_dq_oe && !flash_ce_n)
		else $error("read while host drives data");
	a_we_width: assert property ($fell(flash_we_n) |-> s_we_low3)
		else $error("write strobe width wrong");
	a_data_stable: assert property (!flash_we_n |=> $stable(pin_dq_out))
		else $error("write data moved under strobe");
	a_read_recovery: assert property ($fell(flash_oe_n) |-> since_wr_reg >= 9'h0F0)
		else $error("read too soon after write");
	a_boot_reset: assert property ($fell(flash_we_n) && !wrote_reg |-> pin_dq_out == 8'hFF)
		else $error("first write after reset not FF");
	a_no_program: assert property ($rose(flash_we_n) && last_cmd_reg == 8'h40 |-> pin_dq_out == 8'hFF)
		else $error("data written after set-up");
	a_take_drop: assert property (s_take |=> !req_ready)
		else $error("ready stayed high after request");
endmodule
bind fcra_host fcra_host_properties chk_u (.core_clk, .sys_rst, .req_valid, .req_op, .req_ready,
	.pin_dq_out, .pin_dq_oe, .flash_ce_n, .flash_we_n, .flash_oe_n);

// ===== sim/fcra_flash_model.sv
// Behavioural flash command register and identification store
`timescale 1ns/1ps
module fcra_flash_model #(
	parameter [7:0] MFR_CODE = 8'h5A, // Arbitrary value
	parameter [7:0] DEV_CODE = 8'h3C  // Arbitrary value
) (
	input  wire logic        ce_n,    // Chip enable
	input  wire logic        we_n,    // Write strobe
	input  wire logic        oe_n,    // Output enable
	input  wire logic [15:0] addr,    // Address
	input  wire logic [7:0]  dq_in,   // Data bus level
	input  wire logic        vpp_low, // Supply at read-only level
	output logic      [7:0]  dq_out,  // Data to host
	output wire logic        dq_oe    // Driving data
);
	logic [1:0]  mode = 2'h0;
	logic        ff_once = 1'b0;
	logic [15:0] addr_lat = 16'h0000;
	logic [7:0]  last_dq = 8'h00;
	int          writes = 0, pulses = 0, id_reads = 0, early_reads = 0;
	realtime     t_wr = -1.0e4;
	assign dq_oe = !ce_n && !oe_n;
	// Released bus shows the inverse so stale data cannot pass
	always @* begin
		if (!dq_oe)
			dq_out = ~last_dq;
		else if (mode == 2'h1)
			dq_out = (addr == 16'h0001) ? DEV_CODE : (addr == 16'h0000) ? MFR_CODE : 8'h00;
		else
			dq_out = addr[7:0] ^ 8'hA5;
	end
	always @(dq_out) if (dq_oe) last_dq = dq_out;
	always @(negedge oe_n) if (!ce_n) begin
		if ($realtime - t_wr < 6000.0) early_reads++;
		if (mode == 2'h1) id_reads++;
	end
	always @(negedge we_n) if (!ce_n) addr_lat = addr;
	always @(posedge we_n) if (!ce_n) begin
		writes++;
		t_wr = $realtime;
		if (mode == 2'h2 && dq_in != 8'hFF) begin
			if (!vpp_low) pulses++;
			mode = 2'h0;
		end else if (dq_in == 8'hFF) begin
			if (ff_once) mode = 2'h0;
			ff_once = !ff_once;
		end else begin
			ff_once = 1'b0;
			case (dq_in)
				8'h00: mode = 2'h0;
				8'h80, 8'h90: mode = 2'h1;
				8'h40: mode = 2'h2;
				default: ;
			endcase
		end
	end
endmodule

// ===== sim/test_fcra_host.sv
// Self-checking bench for the flash host sequencer
`timescale 1ns/1ps
module test_fcra_host;
	logic        core_clk = 0, sys_rst = 1, req_valid = 0, vpp_lo = 0;
	logic [2:0]  req_op = 0;
	wire         req_ready, resp_valid, supply_low, dq_oe, ce_n, we_n, oe_n;
	wire  [7:0]  mfr, dev, dq_o, m_dq, dq;
	wire  [15:0] addr;
	int          err_count = 0, checked = 0;
	assign dq = dq_oe ? dq_o : m_dq;
	fcra_host dut_u (.core_clk, .sys_rst, .clk_en(1'b1), .req_valid, .req_op, .pin_dq_in(dq),
		.program_supply_low_level(vpp_lo), .req_ready, .resp_valid, .resp_mfr(mfr), .resp_dev(dev),
		.supply_low, .pin_addr(addr), .pin_dq_out(dq_o), .pin_dq_oe(dq_oe), .flash_ce_n(ce_n),
		.flash_we_n(we_n), .flash_oe_n(oe_n));
	fcra_flash_model flash_u (.ce_n, .we_n, .oe_n, .addr, .dq_in(dq), .vpp_low(vpp_lo), .dq_out(m_dq), .dq_oe());
	initial forever #12.5 core_clk = ~core_clk;
	task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task end_of_test;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task wait_for(input int which);
		int i;
		for (i = 0; i < 5000 && (which ? resp_valid : req_ready) !== 1'b1; i++) @(negedge core_clk);
		if ((which ? resp_valid : req_ready) !== 1'b1) begin
			err_count++;
			end_of_test;
		end
	endtask
	task run_op(input logic [2:0] op, input int hold);
		wait_for(0);
		req_valid = 1;
		req_op = op;
		repeat (hold) @(negedge core_clk);
		req_valid = 0;
		wait_for(1);
	endtask
	task t_identify;
		int w;
		int r;
		w = flash_u.writes;
		r = flash_u.id_reads;
		run_op(3'h2, 1);
		check("maker code", mfr, flash_u.MFR_CODE);
		check("device code", dev, flash_u.DEV_CODE);
		check("id reads", 16'(flash_u.id_reads - r), 16'h2);
		check("id writes", 16'(flash_u.writes - w), 16'h2);
		check("mode after id", flash_u.mode, 16'h0);
	endtask
	task t_abort(input logic lo);
		int w;
		@(negedge core_clk);
		vpp_lo = lo;
		repeat (4) @(negedge core_clk);
		check("supply low", supply_low, lo);
		w = flash_u.writes;
		run_op(3'h4, 1);
		check("abort writes", 16'(flash_u.writes - w), 16'h3);
		check("abort mode", flash_u.mode, 16'h0);
		check("pulses", 16'(flash_u.pulses), 16'h0);
	endtask
	task t_reset_twice;
		run_op(3'h1, 1);
		run_op(3'h1, 1);
		check("reset mode", flash_u.mode, 16'h0);
	endtask
	task t_refused;
		int w;
		w = flash_u.writes;
		// Request stays up while busy; only the first is taken
		run_op(3'h3, 20);
		check("single op", 16'(flash_u.writes - w), 16'h1);
	endtask
	initial begin
		repeat (5) @(negedge core_clk);
		sys_rst = 0;
		wait_for(0);
		check("boot writes", 16'(flash_u.writes), 16'h2);
		check("boot mode", flash_u.mode, 16'h0);
		t_identify;
		t_abort(1'b0);
		t_abort(1'b1);
		t_reset_twice;
		t_refused;
		t_identify;
		check("early reads", 16'(flash_u.early_reads), 16'h0);
		end_of_test;
	end
endmodule
